// File: split_timer_pkg.sv
// Constants and carrier types for the split-mode timer control block.
// Assumes an 8-bit special-function-register port clocked by the system clock.
`default_nettype none

package split_timer_pkg;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] TIMER_CONTROL_STATUS_ADDR = 8'h88;
   localparam logic [7:0] FIRST_LOW_ADDR = 8'h8A;
   localparam logic [7:0] SECOND_LOW_ADDR = 8'h8B;
   localparam logic [7:0] FIRST_HIGH_ADDR = 8'h8C;
   localparam logic [7:0] SECOND_HIGH_ADDR = 8'h8D;

   // ------------------------------------------------------------
   // Reset values and counter limits
   // ------------------------------------------------------------
   localparam logic [7:0] TIMER_CONTROL_STATUS_RESET = 8'h00;
   localparam logic [7:0] COUNT_BYTE_RESET = 8'h00;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [12:0] WORD13_ALL_ONES = 13'h1FFF;
   localparam logic [15:0] WORD16_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ------------------------------------------------------------
   // Field positions of the mode select register
   // ------------------------------------------------------------
   localparam int FIRST_CFG_LSB = 0;
   localparam int SECOND_CFG_LSB = 4;
   localparam int CFG_WIDTH = 4;

   // Timer operating modes, in field-code order
   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD8,
      MODE_SPLIT
   } timer_mode_t;

   // One timer's half of the mode select register
   typedef struct packed {
      logic gate;
      logic count_src;
      timer_mode_t mode;
   } timer_cfg_t;

   // Control and status register, bit 7 first
   typedef struct packed {
      logic second_timer_overflow_flag;
      logic second_timer_run;
      logic first_timer_overflow_flag;
      logic first_timer_run;
      logic ext_irq_b_flag;
      logic ext_irq_b_trigger_type;
      logic ext_irq_a_flag;
      logic ext_irq_a_trigger_type;
   } timer_control_status_t;

endpackage : split_timer_pkg

`default_nettype wire

// File: split_timer_mode3_control.sv
// Split-mode first timer, second timer, and the shared control/status register.
// Assumes all inputs synchronous to clk; the mode select register lives elsewhere.
//
// Summary of operation
// - Split mode runs the first timer's two bytes as independent 8-bit counters.
// - Low byte uses the first timer's run, source, gate and overflow flag.
// - Low byte counts system/prescaled ticks or count-pin falls per source bit.
// - High byte only times from system or prescaled clock, never the pin.
// - High byte counts only while the second timer's run bit is set.
// - High byte overflow sets the second timer's overflow flag.
// - Split keeps second timer off its pin and off its overflow flag.
// - Second timer overflows still go out as baud and conversion tick.
// - Second timer in mode 3 holds its count.
// - First overflow flag set on overflow, cleared by software or vectoring.
// - First run bit 0 stops, 1 enables subject to gate.
// - External flag b set on edge or level chosen by its trigger bit.
// - External flag b cleared by software or on vectoring when edge-triggered.
// - Trigger bit 0 level-sensitive, flag follows level; 1 edge-sensitive.
// - External counting increments on count-pin high-to-low transitions.
// - Low byte and non-split second timer count only when run is 1 and gate is 0 or input active.
`timescale 1ns/1ps
`default_nettype none

module split_timer_mode3_control
   import split_timer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [7:0] timer_mode_select_reg,
   input wire logic first_sysclk_select,
   input wire logic second_sysclk_select,
   input wire logic prescaled_tick,
   input wire logic first_count_pin,
   input wire logic second_count_pin,
   input wire logic ext_irq_a_input,
   input wire logic ext_irq_b_input,
   input wire logic ext_irq_a_polarity,
   input wire logic ext_irq_b_polarity,
   input wire logic vector_first_timer,
   input wire logic vector_second_timer,
   input wire logic vector_ext_a,
   input wire logic vector_ext_b,
   output timer_control_status_t timer_control_status,
   output logic second_timer_overflow_tick
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic flag_next(input logic cur, input logic wr, input logic wbit,
                                      input logic vec, input logic set);
      flag_next = ((wr ? wbit : cur) & ~vec) | set;
   endfunction : flag_next

   function automatic logic irq_next(input logic cur, input logic wr, input logic wbit, input logic vec,
                                     input logic edge_mode, input logic act, input logic prev_act);
      irq_next = edge_mode ? flag_next(cur, wr, wbit, vec, act & ~prev_act) : act;
   endfunction : irq_next

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   timer_control_status_t tcs;
   logic [7:0] first_timer_low_byte;
   logic [7:0] first_timer_high_byte;
   logic [7:0] second_timer_low_byte;
   logic [7:0] second_timer_high_byte;
   logic prev_count_a;
   logic prev_count_b;
   logic prev_active_a;
   logic prev_active_b;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire timer_cfg_t cfg0 = timer_cfg_t'(timer_mode_select_reg[FIRST_CFG_LSB +: CFG_WIDTH]);
   wire timer_cfg_t cfg1 = timer_cfg_t'(timer_mode_select_reg[SECOND_CFG_LSB +: CFG_WIDTH]);
   wire split = (cfg0.mode == MODE_SPLIT);
   wire wr_tcs = sfr_wr && (sfr_addr == TIMER_CONTROL_STATUS_ADDR);
   wire wr_low = sfr_wr && (sfr_addr == FIRST_LOW_ADDR);
   wire wr_high = sfr_wr && (sfr_addr == FIRST_HIGH_ADDR);
   wire wr_t1l = sfr_wr && (sfr_addr == SECOND_LOW_ADDR);
   wire wr_t1h = sfr_wr && (sfr_addr == SECOND_HIGH_ADDR);
   wire timer_control_status_t wr_bits = timer_control_status_t'(sfr_wdata);

   // Polarity bit 1 means active high
   wire active_a = ext_irq_a_input ~^ ext_irq_a_polarity;
   wire active_b = ext_irq_b_input ~^ ext_irq_b_polarity;

   wire fall_a = prev_count_a & ~first_count_pin;
   wire fall_b = prev_count_b & ~second_count_pin;
   wire tick_a = first_sysclk_select | prescaled_tick;
   wire tick_b = second_sysclk_select | prescaled_tick;

   // ------------------------------------------------------------
   // First timer halves
   // ------------------------------------------------------------
   // low byte gating
   wire low_inc = split && tcs.first_timer_run && (!cfg0.gate || active_a) && (cfg0.count_src ? fall_a : tick_a);
   // high byte on second run bit
   wire high_inc = split && tcs.second_timer_run && tick_a;
   wire low_ovf = low_inc && (first_timer_low_byte == BYTE_ALL_ONES);
   wire high_ovf = high_inc && (first_timer_high_byte == BYTE_ALL_ONES);

   // ------------------------------------------------------------
   // Second timer
   // ------------------------------------------------------------
   // mode 3 holds; split uses mode instead of run bit
   wire t1_run = (cfg1.mode != MODE_SPLIT) && (split || (tcs.second_timer_run && (!cfg1.gate || active_b)));
   wire t1_inc = t1_run && ((cfg1.count_src && !split) ? fall_b : tick_b);
   wire [12:0] t1_w13 = {second_timer_high_byte, second_timer_low_byte[4:0]};
   wire [15:0] t1_w16 = {second_timer_high_byte, second_timer_low_byte};
   wire [12:0] t1_n13 = t1_w13 + 13'h0001;
   wire [15:0] t1_n16 = t1_w16 + 16'h0001;
   logic t1_at_top;
   always_comb
   begin
      unique case (cfg1.mode)
         MODE_13BIT: t1_at_top = (t1_w13 == WORD13_ALL_ONES);
         MODE_16BIT: t1_at_top = (t1_w16 == WORD16_ALL_ONES);
         MODE_RELOAD8: t1_at_top = (second_timer_low_byte == BYTE_ALL_ONES);
         MODE_SPLIT: t1_at_top = 1'b0;
      endcase
   end
   wire t1_ovf = t1_inc && t1_at_top;
   wire set_second_flag = high_ovf || (t1_ovf && !split);

   // ------------------------------------------------------------
   // Sequential
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tcs <= timer_control_status_t'(TIMER_CONTROL_STATUS_RESET);
         first_timer_low_byte <= COUNT_BYTE_RESET;
         first_timer_high_byte <= COUNT_BYTE_RESET;
         second_timer_low_byte <= COUNT_BYTE_RESET;
         second_timer_high_byte <= COUNT_BYTE_RESET;
         prev_count_a <= 1'b0;
         prev_count_b <= 1'b0;
         prev_active_a <= 1'b0;
         prev_active_b <= 1'b0;
         second_timer_overflow_tick <= 1'b0;
         sfr_rdata <= READ_UNMAPPED;
      end
      else if (ce)
      begin
         prev_count_a <= first_count_pin;
         prev_count_b <= second_count_pin;
         prev_active_a <= active_a;
         prev_active_b <= active_b;
         // overflow tick out in any split state
         second_timer_overflow_tick <= t1_ovf;
         tcs.first_timer_run <= wr_tcs ? wr_bits.first_timer_run : tcs.first_timer_run;
         tcs.second_timer_run <= wr_tcs ? wr_bits.second_timer_run : tcs.second_timer_run;
         tcs.ext_irq_a_trigger_type <= wr_tcs ? wr_bits.ext_irq_a_trigger_type : tcs.ext_irq_a_trigger_type;
         tcs.ext_irq_b_trigger_type <= wr_tcs ? wr_bits.ext_irq_b_trigger_type : tcs.ext_irq_b_trigger_type;
         tcs.first_timer_overflow_flag <= flag_next(tcs.first_timer_overflow_flag, wr_tcs,
            wr_bits.first_timer_overflow_flag, vector_first_timer, low_ovf);
         tcs.second_timer_overflow_flag <= flag_next(tcs.second_timer_overflow_flag, wr_tcs,
            wr_bits.second_timer_overflow_flag, vector_second_timer, set_second_flag);
         tcs.ext_irq_a_flag <= irq_next(tcs.ext_irq_a_flag, wr_tcs, wr_bits.ext_irq_a_flag, vector_ext_a,
            tcs.ext_irq_a_trigger_type, active_a, prev_active_a);
         tcs.ext_irq_b_flag <= irq_next(tcs.ext_irq_b_flag, wr_tcs, wr_bits.ext_irq_b_flag, vector_ext_b,
            tcs.ext_irq_b_trigger_type, active_b, prev_active_b);
         // Software loads take precedence over a count
         if (wr_low)
            first_timer_low_byte <= sfr_wdata;
         else if (low_inc)
            first_timer_low_byte <= first_timer_low_byte + 8'h01;
         if (wr_high)
            first_timer_high_byte <= sfr_wdata;
         else if (high_inc)
            first_timer_high_byte <= first_timer_high_byte + 8'h01;
         if (wr_t1l)
            second_timer_low_byte <= sfr_wdata;
         if (wr_t1h)
            second_timer_high_byte <= sfr_wdata;
         if (t1_inc && !wr_t1l && !wr_t1h)
         begin
            unique case (cfg1.mode)
               MODE_13BIT: {second_timer_high_byte, second_timer_low_byte[4:0]} <= t1_n13;
               MODE_16BIT: {second_timer_high_byte, second_timer_low_byte} <= t1_n16;
               MODE_RELOAD8: second_timer_low_byte <= t1_at_top ? second_timer_high_byte
                                                                : second_timer_low_byte + 8'h01;
               MODE_SPLIT: second_timer_low_byte <= second_timer_low_byte;
            endcase
         end
         if (sfr_rd)
         begin
            unique case (sfr_addr)
               TIMER_CONTROL_STATUS_ADDR: sfr_rdata <= tcs;
               FIRST_LOW_ADDR: sfr_rdata <= first_timer_low_byte;
               FIRST_HIGH_ADDR: sfr_rdata <= first_timer_high_byte;
               SECOND_LOW_ADDR: sfr_rdata <= second_timer_low_byte;
               SECOND_HIGH_ADDR: sfr_rdata <= second_timer_high_byte;
               default: sfr_rdata <= READ_UNMAPPED;
            endcase
         end
      end
   end
   assign timer_control_status = tcs;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_low_wrap;
      @(posedge clk) disable iff (rst)
      ce && low_ovf && !wr_low |=> first_timer_low_byte == BYTE_ZERO;
   endproperty
   a_low_wrap: assert property (p_low_wrap) else $error("low byte did not wrap to zero");

   property p_first_flag_set;
      @(posedge clk) disable iff (rst)
      ce && low_ovf |=> tcs.first_timer_overflow_flag;
   endproperty
   a_first_flag_set: assert property (p_first_flag_set) else $error("first overflow flag not set");

   property p_high_second_flag;
      @(posedge clk) disable iff (rst)
      ce && split && tcs.second_timer_run && tick_a && &first_timer_high_byte |=> tcs.second_timer_overflow_flag;
   endproperty
   a_high_second_flag: assert property (p_high_second_flag) else $error("high byte overflow missed flag");

   property p_high_needs_tr1;
      @(posedge clk) disable iff (rst)
      ce && split && !tcs.second_timer_run && !wr_high |=> $stable(first_timer_high_byte);
   endproperty
   a_high_needs_tr1: assert property (p_high_needs_tr1) else $error("high byte ran without run bit");

   property p_low_stop;
      @(posedge clk) disable iff (rst)
      ce && !tcs.first_timer_run && !wr_low |=> $stable(first_timer_low_byte);
   endproperty
   a_low_stop: assert property (p_low_stop) else $error("low byte ran while disabled");

   property p_pin_fall_only;
      @(posedge clk) disable iff (rst)
      ce && split && tcs.first_timer_run && !cfg0.gate && cfg0.count_src && !wr_low
         ##0 !(prev_count_a && !first_count_pin) |=> $stable(first_timer_low_byte);
   endproperty
   a_pin_fall_only: assert property (p_pin_fall_only) else $error("low byte counted without pin fall");

   property p_split_no_t1_flag;
      @(posedge clk) disable iff (rst)
      ce && split && !tcs.second_timer_overflow_flag && !wr_tcs && !high_ovf |=> !tcs.second_timer_overflow_flag;
   endproperty
   a_split_no_t1_flag: assert property (p_split_no_t1_flag) else $error("second timer set flag while split");

   property p_t1_tick;
      @(posedge clk) disable iff (rst)
      ce && t1_ovf |=> second_timer_overflow_tick;
   endproperty
   a_t1_tick: assert property (p_t1_tick) else $error("second timer overflow tick lost");

   property p_t1_mode3_hold;
      @(posedge clk) disable iff (rst)
      ce && cfg1.mode == MODE_SPLIT && !wr_t1l && !wr_t1h |=> $stable(t1_w16);
   endproperty
   a_t1_mode3_hold: assert property (p_t1_mode3_hold) else $error("second timer moved in mode 3");

   property p_irq_b_edge;
      @(posedge clk) disable iff (rst)
      ce && tcs.ext_irq_b_trigger_type && active_b && !prev_active_b |=> tcs.ext_irq_b_flag;
   endproperty
   a_irq_b_edge: assert property (p_irq_b_edge) else $error("edge flag b not set");

   property p_irq_b_level;
      @(posedge clk) disable iff (rst)
      ce && !tcs.ext_irq_b_trigger_type && !wr_tcs |=> tcs.ext_irq_b_flag == $past(active_b);
   endproperty
   a_irq_b_level: assert property (p_irq_b_level) else $error("level flag b does not follow input");

   property p_irq_b_vector;
      @(posedge clk) disable iff (rst)
      ce && tcs.ext_irq_b_trigger_type && vector_ext_b && !wr_tcs && !(active_b && !prev_active_b) |=> !tcs.ext_irq_b_flag;
   endproperty
   a_irq_b_vector: assert property (p_irq_b_vector) else $error("flag b not cleared on vectoring");

endmodule : split_timer_mode3_control

`default_nettype wire

// File: test_split_timer_mode3_control.sv
// Self-checking bench for the split-mode timer control block.
// Assumes the block's package and its registered, one-cycle-late read port.
`timescale 1ns/1ps
`default_nettype none

module test_split_timer_mode3_control;
   import split_timer_pkg::*;

   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, timer_mode_select_reg = 8'h33;
   logic first_sysclk_select = 1'b0, second_sysclk_select = 1'b0, prescaled_tick = 1'b0;
   logic first_count_pin = 1'b1, second_count_pin = 1'b1;
   logic ext_irq_a_input = 1'b0, ext_irq_b_input = 1'b0, ext_irq_a_polarity = 1'b1, ext_irq_b_polarity = 1'b1;
   logic vector_first_timer = 1'b0, vector_second_timer = 1'b0, vector_ext_a = 1'b0, vector_ext_b = 1'b0;
   logic [7:0] sfr_rdata;
   timer_control_status_t timer_control_status;
   logic second_timer_overflow_tick;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;
   int n_fail = 0, checked = 0, seed = 86010, cyc = 0, tick_cnt = 0;
   localparam logic [7:0] CSR = TIMER_CONTROL_STATUS_ADDR;

   split_timer_mode3_control DUT (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_mode_select_reg(timer_mode_select_reg),
      .first_sysclk_select(first_sysclk_select), .second_sysclk_select(second_sysclk_select),
      .prescaled_tick(prescaled_tick), .first_count_pin(first_count_pin), .second_count_pin(second_count_pin),
      .ext_irq_a_input(ext_irq_a_input), .ext_irq_b_input(ext_irq_b_input),
      .ext_irq_a_polarity(ext_irq_a_polarity), .ext_irq_b_polarity(ext_irq_b_polarity),
      .vector_first_timer(vector_first_timer), .vector_second_timer(vector_second_timer),
      .vector_ext_a(vector_ext_a), .vector_ext_b(vector_ext_b),
      .timer_control_status(timer_control_status), .second_timer_overflow_tick(second_timer_overflow_tick));

   always #10 clk = ~clk;

   // ------------------------------------------------------------
   // Reporting and comparison
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_count(input int got, input int exp);
      checked++;
      if (got != exp)
      begin
         n_fail++;
         $display("mismatch at %0t: %0d ticks expected %0d", $time, got, exp);
      end
   endtask : chk_count

   // Watcher: read data lands one cycle after the strobe edge
   always @(posedge clk)
   begin
      rd_seen <= sfr_rd & ~rst;
      if (second_timer_overflow_tick !== 1'b0)
         tick_cnt++;
      cyc++;
      if (cyc == 4000)
      begin
         n_fail++;
         stop_test();
      end
   end

   always @(negedge clk)
      if (rd_seen && exp_q.size() > 0)
         chk_byte(sfr_rdata, exp_q.pop_front());

   // ------------------------------------------------------------
   // Drivers, all launched on the falling edge
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      exp_q.push_back(e);
      @(negedge clk);
      sfr_rd = 1'b0;
   endtask : rd_reg

   task automatic ticks(input int n);
      repeat (n)
      begin
         @(negedge clk);
         prescaled_tick = 1'b1;
         @(negedge clk);
         prescaled_tick = 1'b0;
      end
   endtask : ticks

   // Pin held two cycles each way so every level is sampled
   task automatic pin_falls(input int n);
      repeat (n)
      begin
         @(negedge clk);
         first_count_pin = 1'b0;
         repeat (2) @(negedge clk);
         first_count_pin = 1'b1;
         repeat (2) @(negedge clk);
      end
   endtask : pin_falls

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [7:0] lo, hi;
      logic [8:0] sl, sh;
      int n;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      rd_reg(CSR, TIMER_CONTROL_STATUS_RESET);
      rd_reg(8'h90, READ_UNMAPPED);
      rd_reg(FIRST_LOW_ADDR, COUNT_BYTE_RESET);
      wr_reg(CSR, 8'h55);
      rd_reg(CSR, 8'h55);
      $display("test reset and access done");
      // Random low-byte starts near the top so several runs wrap
      for (int i = 0; i < 6; i++)
      begin
         lo = 8'hF0 | 8'($random(seed));
         hi = 8'($random(seed));
         n = ($random(seed) & 15) + 1;
         sl = {1'b0, lo} + 9'(n);
         sh = {1'b0, hi} + 9'(n);
         wr_reg(CSR, 8'h55);
         wr_reg(FIRST_LOW_ADDR, lo);
         wr_reg(FIRST_HIGH_ADDR, hi);
         ticks(n);
         rd_reg(CSR, {sh[8], 1'b1, sl[8], 5'b10101});
         rd_reg(FIRST_LOW_ADDR, sl[7:0]);
         rd_reg(FIRST_HIGH_ADDR, sh[7:0]);
      end
      $display("test split counting done");
      wr_reg(CSR, 8'h15);
      wr_reg(FIRST_HIGH_ADDR, 8'h20);
      wr_reg(FIRST_LOW_ADDR, 8'h00);
      ticks(5);
      rd_reg(FIRST_LOW_ADDR, 8'h05);
      rd_reg(FIRST_HIGH_ADDR, 8'h20);
      wr_reg(CSR, 8'h45);
      ticks(3);
      rd_reg(FIRST_LOW_ADDR, 8'h05);
      rd_reg(FIRST_HIGH_ADDR, 8'h23);
      ce = 1'b0;
      ticks(2);
      ce = 1'b1;
      rd_reg(FIRST_HIGH_ADDR, 8'h23);
      $display("test run bits done");
      timer_mode_select_reg = 8'h37;
      wr_reg(CSR, 8'h55);
      wr_reg(FIRST_LOW_ADDR, 8'h00);
      wr_reg(FIRST_HIGH_ADDR, 8'h00);
      pin_falls(3);
      rd_reg(FIRST_LOW_ADDR, 8'h03);
      rd_reg(FIRST_HIGH_ADDR, 8'h00);
      ticks(4);
      rd_reg(FIRST_LOW_ADDR, 8'h03);
      rd_reg(FIRST_HIGH_ADDR, 8'h04);
      $display("test count sources done");
      timer_mode_select_reg = 8'h3B;
      wr_reg(FIRST_LOW_ADDR, 8'h00);
      ticks(3);
      rd_reg(FIRST_LOW_ADDR, 8'h00);
      ext_irq_a_input = 1'b1;
      ticks(2);
      rd_reg(FIRST_LOW_ADDR, 8'h02);
      ext_irq_a_input = 1'b0;
      $display("test gate done");
      timer_mode_select_reg = 8'h33;
      wr_reg(CSR, 8'h15);
      wr_reg(FIRST_LOW_ADDR, 8'hFF);
      ticks(1);
      rd_reg(CSR, 8'h35);
      @(negedge clk);
      vector_first_timer = 1'b1;
      @(negedge clk);
      vector_first_timer = 1'b0;
      rd_reg(CSR, 8'h15);
      wr_reg(FIRST_LOW_ADDR, 8'hFF);
      @(negedge clk);
      prescaled_tick = 1'b1;
      sfr_addr = CSR;
      sfr_wdata = 8'h15;
      sfr_wr = 1'b1;
      @(negedge clk);
      prescaled_tick = 1'b0;
      sfr_wr = 1'b0;
      rd_reg(CSR, 8'h35);
      wr_reg(CSR, 8'h40);
      wr_reg(FIRST_HIGH_ADDR, 8'hFF);
      ticks(1);
      rd_reg(CSR, 8'hC0);
      @(negedge clk);
      vector_second_timer = 1'b1;
      @(negedge clk);
      vector_second_timer = 1'b0;
      rd_reg(CSR, 8'h40);
      $display("test overflow flag done");
      wr_reg(CSR, 8'h04);
      ext_irq_b_input = 1'b1;
      rd_reg(CSR, 8'h0C);
      @(negedge clk);
      vector_ext_b = 1'b1;
      @(negedge clk);
      vector_ext_b = 1'b0;
      rd_reg(CSR, 8'h04);
      ext_irq_b_input = 1'b0;
      wr_reg(CSR, 8'h00);
      ext_irq_b_input = 1'b1;
      rd_reg(CSR, 8'h08);
      ext_irq_b_input = 1'b0;
      rd_reg(CSR, 8'h00);
      ext_irq_b_polarity = 1'b0;
      rd_reg(CSR, 8'h08);
      chk_byte(timer_control_status, 8'h08);
      ext_irq_b_polarity = 1'b1;
      $display("test external flag done");
      // Reload of 0xFC gives one overflow every four clocks
      second_sysclk_select = 1'b1;
      timer_mode_select_reg = 8'h63;
      wr_reg(CSR, 8'h00);
      wr_reg(SECOND_HIGH_ADDR, 8'hFC);
      wr_reg(SECOND_LOW_ADDR, 8'hFC);
      repeat (10) @(negedge clk);
      tick_cnt = 0;
      repeat (40) @(negedge clk);
      chk_count(tick_cnt, 10);
      rd_reg(CSR, 8'h00);
      timer_mode_select_reg = 8'h73;
      repeat (4) @(negedge clk);
      tick_cnt = 0;
      repeat (20) @(negedge clk);
      chk_count(tick_cnt, 0);
      $display("test second timer done");
      repeat (2) @(negedge clk);
      stop_test();
   end
endmodule : test_split_timer_mode3_control

`default_nettype wire
